// ### core/timer_unit_pkg.sv
// Shared addresses, bit positions, reset values and timing counts for the timer unit
package timer_unit_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  // Register byte addresses
  localparam logic [7:0] ADDR_PAIR_CONTROL = 8'h88;
  localparam logic [7:0] ADDR_PAIR_MODE = 8'h89;
  localparam logic [7:0] ADDR_T0_LOW = 8'h8A;
  localparam logic [7:0] ADDR_T1_LOW = 8'h8B;
  localparam logic [7:0] ADDR_T0_HIGH = 8'h8C;
  localparam logic [7:0] ADDR_T1_HIGH = 8'h8D;
  localparam logic [7:0] ADDR_T2_CONTROL = 8'hC8;
  localparam logic [7:0] ADDR_T2_RELOAD_LOW = 8'hCA;
  localparam logic [7:0] ADDR_T2_RELOAD_HIGH = 8'hCB;
  localparam logic [7:0] ADDR_T2_LOW = 8'hCC;
  localparam logic [7:0] ADDR_T2_HIGH = 8'hCD;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'hB0;
  localparam logic [7:0] ADDR_IRQ_CLEAR = 8'hB1;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'hB2;
  // Pair control bits
  localparam int PC_TF1 = 7;
  localparam int PC_TR1 = 6;
  localparam int PC_TF0 = 5;
  localparam int PC_TR0 = 4;
  // Pair mode nibble layout (timer 0 low nibble, timer 1 high nibble)
  localparam int PM_GATE = 3;
  localparam int PM_CT = 2;
  localparam logic [1:0] MODE_13BIT = 2'h0;
  localparam logic [1:0] MODE_16BIT = 2'h1;
  localparam logic [1:0] MODE_8BIT_RELOAD = 2'h2;
  localparam logic [1:0] MODE_SPLIT = 2'h3;
  // Timer two control bits
  localparam int T2C_TF2 = 7;
  localparam int T2C_EXF2 = 6;
  localparam int T2C_RCLK = 5;
  localparam int T2C_TCLK = 4;
  localparam int T2C_EXEN2 = 3;
  localparam int T2C_TR2 = 2;
  localparam int T2C_CT2 = 1;
  localparam int T2C_CAPTURE = 0;
  // Interrupt status bits
  localparam int IRQ_W = 4;
  localparam int IRQ_T0 = 0;
  localparam int IRQ_T1 = 1;
  localparam int IRQ_T2 = 2;
  localparam int IRQ_EXT2 = 3;
  // Core clock is the input clock divided by this
  localparam int CORE_DIV = 2;
  // Core cycles per timer increment
  localparam int MACHINE_CORE_TICKS = 6;
  typedef enum logic [1:0] {T2_CAPTURE, T2_RELOAD, T2_BAUD} t2_mode_e;
endpackage : timer_unit_pkg

// ### core/rate_divider.sv
// Core clock enable and timer increment tick generator
`timescale 1ns/1ps
module rate_divider #(
  parameter int CORE_DIV = timer_unit_pkg::CORE_DIV,
  parameter int TICKS = timer_unit_pkg::MACHINE_CORE_TICKS
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  output logic o_core_tick,
  output logic o_timer_tick
);
  import timer_unit_pkg::*;
  logic [3:0] div_q;
  logic [7:0] mc_q;
  // Dividing by two keeps timing independent of input duty cycle
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst || div_q == 4'(CORE_DIV - 1))
      div_q <= 4'h0;
    else
      div_q <= div_q + 4'h1;
  end
  assign o_core_tick = (div_q == 4'(CORE_DIV - 1)); // RQ8
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
      mc_q <= 8'h00;
    else if (o_core_tick)
      mc_q <= (mc_q == 8'(TICKS - 1)) ? 8'h00 : mc_q + 8'h01;
  end
  assign o_timer_tick = o_core_tick && (mc_q == 8'(TICKS - 1));
endmodule : rate_divider

// ### core/fall_detect.sv
// Falling edge detection of event inputs, sampled on the core tick
`timescale 1ns/1ps
module fall_detect #(
  parameter int N = 4
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_sample,
  input wire logic [N-1:0] i_level,
  output logic [N-1:0] o_fall
);
  logic [N-1:0] prev_q;
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
      prev_q <= '0;
    else if (i_sample)
      prev_q <= i_level;
  end
  // Edges only count at core rate, so pulses shorter than two clocks may be missed
  assign o_fall = {N{i_sample}} & prev_q & ~i_level;
endmodule : fall_detect

// ### core/three_timer_counter_unit.sv
// Three timer/counters with register port, interrupt status and baud tick
//
// The address-and-strobe port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
// How it works
// RQ1: each timer counts in low and high bytes
// RQ2: timers zero and one share control, mode
// RQ3: timer two is 16-bit, own control register
// RQ4: reload/capture byte pair serves timer two
// RQ5: select bit picks external events or clock
// RQ6: timer two modes: capture, reload, baud
// RQ7: timer two internal rate equals timers zero/one; in baud mode it counts every core tick instead
// RQ8: core clock is input clock divided two
// RQ9: reset clears all timer registers to zero
// RQ10: reload mode overflow sets flag, reloads count
// RQ11: capture edge copies count, sets capture flag
module three_timer_counter_unit (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic [timer_unit_pkg::ADDR_W-1:0] i_addr,
  input wire logic [timer_unit_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [2:0] i_count_in,
  input wire logic i_t2_trigger,
  input wire logic [1:0] i_gate_in,
  output logic [timer_unit_pkg::DATA_W-1:0] o_rdata_q,
  output logic o_irq_q,
  output logic o_baud_tick_q
);
  import timer_unit_pkg::*;

  logic core_tick;
  logic timer_tick;
  logic [3:0] ev;
  logic [7:0] ctl_q;
  logic [7:0] mode_q;
  logic [7:0] t0l_q;
  logic [7:0] t0h_q;
  logic [7:0] t1l_q;
  logic [7:0] t1h_q;
  logic [7:0] t2c_q;
  logic [15:0] t2_q;
  logic [15:0] rcap_q;
  logic [IRQ_W-1:0] stat_q;
  logic [IRQ_W-1:0] en_q;
  logic [16:0] step0;
  logic [16:0] step1;
  logic [8:0] step0h;
  logic inc0;
  logic inc1;
  logic inc0h;
  logic ovf0;
  logic ovf1;
  logic t2_inc;
  logic t2_ovf;
  logic t2_trig;
  logic tf2_set;
  logic exf2_set;
  logic [IRQ_W-1:0] events;
  t2_mode_e t2_mode;

  rate_divider #(
    .CORE_DIV(CORE_DIV),
    .TICKS(MACHINE_CORE_TICKS)
  ) u_div (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .o_core_tick(core_tick),
    .o_timer_tick(timer_tick)
  );

  fall_detect #(
    .N(4)
  ) u_edges (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_sample(core_tick),
    .i_level({i_t2_trigger, i_count_in}),
    .o_fall(ev)
  );

  function automatic logic wr_at(input logic [7:0] a);
    wr_at = i_wr && (i_addr == a);
  endfunction : wr_at

  // One increment of a pair timer: returns overflow, high byte, low byte
  function automatic logic [16:0] pair_step(input logic [1:0] m, input logic [7:0] h,
                                            input logic [7:0] l);
    logic [5:0] l5;
    logic [8:0] h9;
    logic [16:0] w;
    l5 = 6'(l[4:0]) + 6'h01;
    h9 = 9'(h) + 9'h001;
    w = 17'(16'({h, l})) + 17'h00001;
    case (m)
      MODE_13BIT:
        pair_step = l5[5] ? {h9[8], h9[7:0], l[7:5], 5'h00} : {1'b0, h, l[7:5], l5[4:0]};
      MODE_8BIT_RELOAD:
        pair_step = (l == 8'hFF) ? {1'b1, h, h} : {1'b0, h, 8'(l + 8'h01)};
      MODE_SPLIT:
        pair_step = (l == 8'hFF) ? {1'b1, h, 8'h00} : {1'b0, h, 8'(l + 8'h01)};
      default:
        pair_step = w;
    endcase
  endfunction : pair_step

  // Gate and source selection of the two paired timers
  assign inc0 = ctl_q[PC_TR0] && (!mode_q[PM_GATE] || i_gate_in[0]) &&
                (mode_q[PM_CT] ? ev[0] : timer_tick); // RQ2
  assign inc1 = (mode_q[1:0] != MODE_SPLIT || mode_q[5:4] != MODE_SPLIT) &&
                (mode_q[5:4] != MODE_SPLIT) &&
                (!mode_q[4+PM_GATE] || i_gate_in[1]) &&
                (mode_q[4+PM_CT] ? ev[1] : timer_tick); // RQ2
  // In split mode the high byte of timer zero borrows timer one's run bit and flag
  assign inc0h = (mode_q[1:0] == MODE_SPLIT) && ctl_q[PC_TR1] && timer_tick;
  assign step0 = pair_step(mode_q[1:0], t0h_q, t0l_q);
  assign step1 = pair_step(mode_q[5:4], t1h_q, t1l_q);
  assign step0h = 9'(t0h_q) + 9'h001;
  assign ovf0 = inc0 && step0[16];
  assign ovf1 = (inc0h && step0h[8]) ||
                (inc1 && ctl_q[PC_TR1] && step1[16] && mode_q[1:0] != MODE_SPLIT);

  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      t0l_q <= RESET_BYTE; // RQ9
      t0h_q <= RESET_BYTE;
    end
    else
    begin
      if (wr_at(ADDR_T0_LOW))
        t0l_q <= i_wdata; // RQ1
      else if (inc0)
        t0l_q <= step0[7:0];
      if (wr_at(ADDR_T0_HIGH))
        t0h_q <= i_wdata; // RQ1
      else if (inc0h)
        t0h_q <= step0h[7:0];
      else if (inc0 && mode_q[1:0] != MODE_SPLIT)
        t0h_q <= step0[15:8];
    end
  end

  // Timer one keeps running without a flag when timer zero is split, unless timer one is split too and halts; baud comes from timer two only
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      t1l_q <= RESET_BYTE; // RQ9
      t1h_q <= RESET_BYTE;
    end
    else
    begin
      if (wr_at(ADDR_T1_LOW))
        t1l_q <= i_wdata; // RQ1
      else if (inc1 && ctl_q[PC_TR1])
        t1l_q <= step1[7:0];
      if (wr_at(ADDR_T1_HIGH))
        t1h_q <= i_wdata; // RQ1
      else if (inc1 && ctl_q[PC_TR1])
        t1h_q <= step1[15:8];
    end
  end

  // Flags set by hardware win over a software clear in the same cycle
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      ctl_q <= RESET_BYTE; // RQ9
      mode_q <= RESET_BYTE;
    end
    else
    begin
      if (wr_at(ADDR_PAIR_CONTROL))
        ctl_q <= i_wdata;
      if (ovf0)
        ctl_q[PC_TF0] <= 1'b1; // RQ2
      if (ovf1)
        ctl_q[PC_TF1] <= 1'b1; // RQ2
      if (wr_at(ADDR_PAIR_MODE))
        mode_q <= i_wdata; // RQ2
    end
  end

  // Timer two mode decode
  always_comb
  begin
    if (t2c_q[T2C_RCLK] || t2c_q[T2C_TCLK])
      t2_mode = T2_BAUD; // RQ6
    else if (t2c_q[T2C_CAPTURE])
      t2_mode = T2_CAPTURE;
    else
      t2_mode = T2_RELOAD;
  end

  assign t2_inc = t2c_q[T2C_TR2] && (t2c_q[T2C_CT2] ? ev[2] :
                  (t2_mode == T2_BAUD ? core_tick : timer_tick)); // RQ5 RQ7
  assign t2_ovf = t2_inc && (t2_q == 16'hFFFF); // RQ3
  assign t2_trig = t2c_q[T2C_EXEN2] && ev[3];
  assign tf2_set = t2_ovf && t2_mode != T2_BAUD;
  assign exf2_set = t2_trig;

  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
      t2_q <= 16'h0000; // RQ9
    else if (wr_at(ADDR_T2_LOW))
      t2_q[7:0] <= i_wdata; // RQ1
    else if (wr_at(ADDR_T2_HIGH))
      t2_q[15:8] <= i_wdata; // RQ1
    else if (t2_mode == T2_RELOAD && t2_trig)
      t2_q <= rcap_q; // RQ10
    else if (t2_ovf && t2_mode != T2_CAPTURE)
      t2_q <= rcap_q; // RQ10
    else if (t2_inc)
      t2_q <= t2_q + 16'h0001; // RQ3
  end

  // A capture edge overrides a software write to the pair in the same cycle
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
      rcap_q <= 16'h0000; // RQ9
    else if (t2_mode == T2_CAPTURE && t2_trig)
      rcap_q <= t2_q; // RQ11
    else if (wr_at(ADDR_T2_RELOAD_LOW))
      rcap_q[7:0] <= i_wdata; // RQ4
    else if (wr_at(ADDR_T2_RELOAD_HIGH))
      rcap_q[15:8] <= i_wdata; // RQ4
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
      t2c_q <= RESET_BYTE; // RQ9
    else
    begin
      if (wr_at(ADDR_T2_CONTROL))
        t2c_q <= i_wdata; // RQ3
      if (tf2_set)
        t2c_q[T2C_TF2] <= 1'b1; // RQ10
      if (exf2_set)
        t2c_q[T2C_EXF2] <= 1'b1; // RQ11
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
      o_baud_tick_q <= 1'b0;
    else
      o_baud_tick_q <= t2_ovf && t2_mode == T2_BAUD; // RQ6
  end

  // Sticky interrupt status, write-one-to-clear, set wins
  assign events = {exf2_set, tf2_set, ovf1, ovf0};
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      stat_q <= '0;
      en_q <= '0;
    end
    else
    begin
      stat_q <= (stat_q & ~(wr_at(ADDR_IRQ_CLEAR) ? i_wdata[IRQ_W-1:0] : '0)) | events;
      if (wr_at(ADDR_IRQ_ENABLE))
        en_q <= i_wdata[IRQ_W-1:0];
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
      o_irq_q <= 1'b0;
    else
      o_irq_q <= |(stat_q & en_q);
  end

  // Read data stand only in the cycle after the strobe; unmapped reads give zero
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst || !i_rd)
      o_rdata_q <= 8'h00;
    else
    begin
      case (i_addr)
        ADDR_PAIR_CONTROL: o_rdata_q <= ctl_q;
        ADDR_PAIR_MODE: o_rdata_q <= mode_q;
        ADDR_T0_LOW: o_rdata_q <= t0l_q; // RQ1
        ADDR_T0_HIGH: o_rdata_q <= t0h_q;
        ADDR_T1_LOW: o_rdata_q <= t1l_q;
        ADDR_T1_HIGH: o_rdata_q <= t1h_q;
        ADDR_T2_CONTROL: o_rdata_q <= t2c_q;
        ADDR_T2_RELOAD_LOW: o_rdata_q <= rcap_q[7:0]; // RQ4
        ADDR_T2_RELOAD_HIGH: o_rdata_q <= rcap_q[15:8];
        ADDR_T2_LOW: o_rdata_q <= t2_q[7:0];
        ADDR_T2_HIGH: o_rdata_q <= t2_q[15:8];
        ADDR_IRQ_STATUS: o_rdata_q <= 8'(stat_q);
        ADDR_IRQ_ENABLE: o_rdata_q <= 8'(en_q);
        default: o_rdata_q <= 8'h00;
      endcase
    end
  end

  reset_clear_a: assert property (@(posedge i_clk_sys) // RQ9
    $past(i_rst) |-> (ctl_q == 8'h00 && mode_q == 8'h00 && t2_q == 16'h0000 &&
                      rcap_q == 16'h0000 && t2c_q == 8'h00))
    else $error("timer registers not cleared by reset");

  core_div_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // RQ8
    core_tick |=> !core_tick)
    else $error("core tick faster than half clock");

  tf0_flag_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // RQ2
    ovf0 |=> ctl_q[PC_TF0] && stat_q[IRQ_T0])
    else $error("timer zero overflow lost");

  read_back_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // RQ1
    (i_rd && i_addr == ADDR_T0_LOW) |=> o_rdata_q == $past(t0l_q))
    else $error("low byte read mismatch");

  t2_rate_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // RQ7
    (!t2c_q[T2C_CT2] && t2_mode != T2_BAUD && !timer_tick && !i_wr && !t2_trig)
    |=> $stable(t2_q))
    else $error("timer two moved off the timer tick");

  t2_select_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // RQ5
    (t2c_q[T2C_CT2] && !ev[2] && !i_wr && !t2_trig) |=> $stable(t2_q))
    else $error("timer two counted without an event");

  t2_wrap_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // RQ3
    (t2_ovf && t2_mode == T2_CAPTURE && !i_wr) |=> t2_q == 16'h0000 && t2c_q[T2C_TF2])
    else $error("timer two did not wrap at sixteen bits");

  reload_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // RQ10
    (t2_ovf && t2_mode == T2_RELOAD && !i_wr) |=> t2_q == $past(rcap_q) && t2c_q[T2C_TF2])
    else $error("auto-reload failed");

  capture_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // RQ11
    (t2_trig && t2_mode == T2_CAPTURE) |=> rcap_q == $past(t2_q) && t2c_q[T2C_EXF2])
    else $error("capture failed");

  baud_mode_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // RQ6
    (t2_ovf && t2_mode == T2_BAUD) |=> o_baud_tick_q ##1 !o_baud_tick_q)
    else $error("baud tick missing or stretched");

  reload_pair_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // RQ4
    (i_wr && i_addr == ADDR_T2_RELOAD_HIGH && !t2_trig) |=> rcap_q[15:8] == $past(i_wdata))
    else $error("reload high byte not written");

  irq_level_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    ##1 o_irq_q == |($past(stat_q) & $past(en_q)))
    else $error("interrupt output disagrees with status");
endmodule : three_timer_counter_unit

// ### sim/event_source.sv
// Far-side model: event inputs, timer-two trigger and gate levels
`timescale 1ns/1ps
module event_source (
  input wire logic i_clk_sys,
  output logic [2:0] o_count_in,
  output logic o_t2_trigger,
  output logic [1:0] o_gate_in
);
  initial
  begin
    o_count_in = 3'h7;
    o_t2_trigger = 1'b1;
    o_gate_in = 2'h3;
  end
  // Each level held four clocks so the two-clock sampler cannot miss it
  task automatic pulse(input int ch, input int n);
    repeat (n)
    begin
      repeat (4) @(posedge i_clk_sys);
      if (ch == 3)
        o_t2_trigger <= 1'b0;
      else
        o_count_in[ch] <= 1'b0;
      repeat (4) @(posedge i_clk_sys);
      if (ch == 3)
        o_t2_trigger <= 1'b1;
      else
        o_count_in[ch] <= 1'b1;
    end
  endtask : pulse
  // Gate levels move just after an edge, like every other far-side input
  task automatic set_gate(input logic [1:0] g);
    @(posedge i_clk_sys);
    o_gate_in <= g;
  endtask : set_gate
endmodule : event_source

// ### sim/tb_three_timer_counter_unit.sv
// Register-level bench for the three timer/counter unit
`timescale 1ns/1ps
module tb_three_timer_counter_unit;
  import timer_unit_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic irq;
  logic baud;
  logic [2:0] count_in;
  logic trig;
  logic [1:0] gate;
  logic [7:0] v;
  logic [7:0] t0;
  logic [7:0] dregs [9] = '{ADDR_PAIR_MODE, ADDR_T0_LOW, ADDR_T1_LOW, ADDR_T0_HIGH,
    ADDR_T1_HIGH, ADDR_T2_RELOAD_LOW, ADDR_T2_RELOAD_HIGH, ADDR_T2_LOW, ADDR_T2_HIGH};
  int miscompares = 0;
  int num_checks = 0;
  int n;

  always #12.5 clk_sys = ~clk_sys;

  event_source u_src (.i_clk_sys(clk_sys), .o_count_in(count_in), .o_t2_trigger(trig),
    .o_gate_in(gate));

  three_timer_counter_unit u_dut (.i_clk_sys(clk_sys), .i_rst(rst), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .i_count_in(count_in), .i_t2_trigger(trig),
    .i_gate_in(gate), .o_rdata_q(rdata), .o_irq_q(irq), .o_baud_tick_q(baud));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask : wr_reg

  // Read data live only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : rd_reg

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd_reg(a, d);
    chk(d, exp);
  endtask : rd_chk

  task automatic wrap_up;
    $display("checks=%0d miscompares=%0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : wrap_up

  initial
  begin
    #(25 * 4000);
    miscompares++;
    wrap_up();
  end

  initial
  begin
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    foreach (dregs[i]) rd_chk(dregs[i], RESET_BYTE);
    rd_chk(ADDR_PAIR_CONTROL, RESET_BYTE);
    rd_chk(ADDR_T2_CONTROL, RESET_BYTE);
    rd_chk(ADDR_IRQ_STATUS, 8'h00);
    foreach (dregs[i]) wr_reg(dregs[i], 8'(8'h11 * (i + 1)));
    foreach (dregs[i]) rd_chk(dregs[i], 8'(8'h11 * (i + 1)));
    wr_reg(ADDR_PAIR_CONTROL, 8'h0F);
    rd_chk(ADDR_PAIR_CONTROL, 8'h0F);
    rd_chk(8'h00, 8'h00);
    rd_chk(ADDR_IRQ_CLEAR, 8'h00);
    // Capture with the timer halted so the copied count is known
    wr_reg(ADDR_IRQ_ENABLE, 8'h08);
    wr_reg(ADDR_T2_CONTROL, 8'h09);
    u_src.pulse(3, 1);
    repeat (4) @(posedge clk_sys);
    rd_chk(ADDR_T2_RELOAD_LOW, 8'h88);
    rd_chk(ADDR_T2_RELOAD_HIGH, 8'h99);
    rd_chk(ADDR_T2_CONTROL, 8'h49);
    chk({7'h00, irq}, 8'h01);
    wr_reg(ADDR_IRQ_CLEAR, 8'h08);
    repeat (2) @(posedge clk_sys);
    rd_chk(ADDR_IRQ_STATUS, 8'h00);
    chk({7'h00, irq}, 8'h00);
    // Event counting through the select bit
    wr_reg(ADDR_T2_LOW, 8'h00);
    wr_reg(ADDR_T2_HIGH, 8'h00);
    wr_reg(ADDR_T2_CONTROL, 8'h06);
    u_src.pulse(2, 5);
    repeat (4) @(posedge clk_sys);
    rd_chk(ADDR_T2_LOW, 8'h05);
    // Auto-reload: two ticks to overflow, 12 clocks per tick
    wr_reg(ADDR_T2_CONTROL, 8'h00);
    wr_reg(ADDR_T2_RELOAD_LOW, 8'hF0);
    wr_reg(ADDR_T2_RELOAD_HIGH, 8'hFF);
    wr_reg(ADDR_T2_LOW, 8'hFE);
    wr_reg(ADDR_T2_HIGH, 8'hFF);
    wr_reg(ADDR_IRQ_ENABLE, 8'h04);
    wr_reg(ADDR_T2_CONTROL, 8'h04);
    n = 0;
    while (irq !== 1'b1 && n < 100)
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    chk(8'(n >= 12 && n <= 30), 8'h01);
    rd_chk(ADDR_T2_CONTROL, 8'h84);
    wr_reg(ADDR_T2_CONTROL, 8'h00);
    rd_chk(ADDR_T2_HIGH, 8'hFF);
    rd_reg(ADDR_T2_LOW, v);
    chk(v >> 1, 8'h78);
    wr_reg(ADDR_IRQ_ENABLE, 8'h00);
    repeat (2) @(posedge clk_sys);
    chk({7'h00, irq}, 8'h00);
    wr_reg(ADDR_IRQ_CLEAR, 8'h04);
    rd_chk(ADDR_IRQ_STATUS, 8'h00);
    // Timer zero and timer two side by side over the same span
    wr_reg(ADDR_T0_LOW, 8'h00);
    wr_reg(ADDR_T2_LOW, 8'h00);
    wr_reg(ADDR_PAIR_MODE, 8'h01);
    wr_reg(ADDR_PAIR_CONTROL, 8'h10);
    wr_reg(ADDR_T2_CONTROL, 8'h04);
    repeat (120) @(posedge clk_sys);
    wr_reg(ADDR_PAIR_CONTROL, 8'h00);
    wr_reg(ADDR_T2_CONTROL, 8'h00);
    rd_reg(ADDR_T0_LOW, t0);
    rd_reg(ADDR_T2_LOW, v);
    chk(8'((t0 - v + 8'h01) <= 8'h02 && v >= 8'h09 && v <= 8'h0B), 8'h01);
    // Baud mode: reload every two core ticks, core tick every two clocks
    wr_reg(ADDR_T2_RELOAD_LOW, 8'hFE);
    wr_reg(ADDR_T2_LOW, 8'hFE);
    wr_reg(ADDR_T2_HIGH, 8'hFF);
    wr_reg(ADDR_T2_CONTROL, 8'h24);
    n = 0;
    while (baud !== 1'b1 && n < 50)
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    n = 0;
    do
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end while (baud !== 1'b1 && n < 50);
    chk(8'(n), 8'h04);
    rd_chk(ADDR_T2_CONTROL, 8'h24);
    wr_reg(ADDR_T2_CONTROL, 8'h00);
    // Timer zero as 8-bit reload event counter, overflow on the second edge
    wr_reg(ADDR_T0_HIGH, 8'hFE);
    wr_reg(ADDR_T0_LOW, 8'hFE);
    wr_reg(ADDR_PAIR_MODE, 8'h06);
    wr_reg(ADDR_PAIR_CONTROL, 8'h10);
    u_src.pulse(0, 2);
    repeat (4) @(posedge clk_sys);
    rd_chk(ADDR_T0_LOW, 8'hFE);
    rd_chk(ADDR_PAIR_CONTROL, 8'h30);
    rd_chk(ADDR_IRQ_STATUS, 8'h01);
    // Gated 13-bit timer zero: held while the gate is low, wraps once it is high
    wr_reg(ADDR_PAIR_CONTROL, 8'h00);
    wr_reg(ADDR_IRQ_CLEAR, 8'h0F);
    u_src.set_gate(2'h2);
    wr_reg(ADDR_T0_LOW, 8'h1F);
    wr_reg(ADDR_T0_HIGH, 8'hFF);
    wr_reg(ADDR_PAIR_MODE, 8'h08);
    wr_reg(ADDR_PAIR_CONTROL, 8'h10);
    repeat (24) @(posedge clk_sys);
    rd_chk(ADDR_T0_LOW, 8'h1F);
    rd_chk(ADDR_IRQ_STATUS, 8'h00);
    u_src.set_gate(2'h3);
    repeat (12) @(posedge clk_sys);
    wr_reg(ADDR_PAIR_CONTROL, 8'h00);
    rd_chk(ADDR_T0_HIGH, 8'h00);
    rd_reg(ADDR_T0_LOW, v);
    chk(v >> 1, 8'h00);
    rd_chk(ADDR_IRQ_STATUS, 8'h01);
    // Split timer zero: its high byte runs under timer one's run bit and flag
    wr_reg(ADDR_IRQ_CLEAR, 8'h0F);
    wr_reg(ADDR_T0_HIGH, 8'hFF);
    wr_reg(ADDR_PAIR_MODE, 8'h33);
    wr_reg(ADDR_PAIR_CONTROL, 8'h40);
    repeat (12) @(posedge clk_sys);
    rd_chk(ADDR_PAIR_CONTROL, 8'hC0);
    wr_reg(ADDR_PAIR_CONTROL, 8'h00);
    rd_chk(ADDR_T1_LOW, 8'h33);
    rd_reg(ADDR_T0_HIGH, v);
    chk(v >> 1, 8'h00);
    rd_chk(ADDR_IRQ_STATUS, 8'h02);
    // Capture mode overflow wraps to zero rather than reloading
    wr_reg(ADDR_T2_LOW, 8'hFF);
    wr_reg(ADDR_T2_HIGH, 8'hFF);
    wr_reg(ADDR_T2_CONTROL, 8'h05);
    repeat (12) @(posedge clk_sys);
    rd_chk(ADDR_T2_CONTROL, 8'h85);
    wr_reg(ADDR_T2_CONTROL, 8'h00);
    rd_chk(ADDR_T2_HIGH, 8'h00);
    rd_chk(ADDR_T2_RELOAD_HIGH, 8'hFF);
    wrap_up();
  end
endmodule : tb_three_timer_counter_unit
